//--- rtl/pbm_cmd_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - Bad-CRC accept keeps bad frames; otherwise they are freed silently.
// - Auto release frees successful packets, no status, no completion entry.
// - Auto release interrupts only on queue drained or fatal error.
// - Fatal error under auto release halts transmitter, logs number, keeps pages.
// - Link-change enable merges link transitions; clearing enable acknowledges.
// - Counter-wrap enable merges rollover; counter read acknowledges.
// - Tx-error enable merges errors; transmitter-on write or clearing acknowledges.
// - Tx error is transmitter-on dropping while tx success stays low.
// - Command field bits 7:5 select eight operations; 000 does nothing.
// - Allocate requests a result at once; page count is ignored.
// - Command 010 resets the buffer manager, interrupts and queue pointers.
// - Command 011 pops the receive queue head.
// - Command 4 pops and frees the head; busy until done.
// - Command 101 frees the packet in the packet select register.
// - Command 110 enqueues the selected packet for transmission.
// - Command 111 empties both transmit queues without freeing memory.
// - Bit 0 reads busy; busy and failed set on write trailing edge.
module pbm_cmd_ctrl
    import pbm_pkg::*;
#(
    parameter int PKT_W = 6
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [2:0] bus_bank,
    input wire logic [3:0] bus_addr,
    input wire logic [1:0] bus_be_n,
    input wire logic bus_wr_n,
    input wire logic bus_rd_n,
    input wire logic [PBM_DW-1:0] bus_wdata,
    output logic [PBM_DW-1:0] bus_rdata,
    input wire logic [PKT_W-1:0] packet_select,
    input wire logic release_done,
    input wire logic alloc_granted,
    output pbm_cmd_t cmd,
    output logic [PKT_W-1:0] cmd_pkt,
    output logic busy,
    output logic alloc_failed,
    output pbm_ctl_t ctl,
    input wire logic link_ok,
    input wire logic counter_wrap_flag,
    input wire logic counter_read,
    input wire logic transmitter_on,
    input wire logic tx_success,
    input wire logic transmitter_on_write_one,
    input wire logic rx_done,
    input wire logic rx_crc_bad,
    input wire pbm_txc_t txc,
    output pbm_txa_t txa,
    output logic rx_keep,
    output logic rx_discard,
    output logic phy_event_interrupt
);
    pbm_st_t st, next_st;
    pbm_op_t op_q, next_op;
    pbm_cmd_t next_cmd;
    pbm_ctl_t next_ctl;
    logic wr_q, pend_q, next_pend, next_failed, wr_now, trail;
    logic hit_cmd, hit_ctl;
    logic [PBM_DW-1:0] next_rdata;
    logic [PKT_W-1:0] next_pkt;

    // Address decode and write strobe tracking
    always_comb begin
        wr_now = !bus_wr_n;
        hit_cmd = bus_bank == PBM_BANK_CMD && bus_addr == PBM_OFS_CMD;
        hit_ctl = bus_bank == PBM_BANK_CTL && bus_addr == PBM_OFS_CTL;
        trail = wr_q && !wr_now;
    end

    // Control register writes, byte lanes honoured
    always_comb begin
        next_ctl = ctl;
        if (wr_now && hit_ctl) begin
            if (!bus_be_n[PBM_LANE_HI]) begin
                next_ctl.bad_crc_accept = bus_wdata[PBM_CTL_BAD];
                next_ctl.auto_release = bus_wdata[PBM_CTL_AUTO];
            end
            if (!bus_be_n[PBM_LANE_LO]) begin
                next_ctl.link_change_irq_en = bus_wdata[PBM_CTL_LE];
                next_ctl.counter_wrap_irq_en = bus_wdata[PBM_CTL_CR];
                next_ctl.tx_error_irq_en = bus_wdata[PBM_CTL_TE];
            end
        end
    end

    // Command capture while the strobe is low, action on its trailing edge
    always_comb begin
        next_op = op_q;
        next_pend = pend_q;
        if (wr_now && hit_cmd && !bus_be_n[PBM_LANE_LO]) begin
            next_op = pbm_op_t'(bus_wdata[PBM_CMD_HI:PBM_CMD_LO]);
            next_pend = 1'b1;
        end else if (trail) begin
            next_pend = 1'b0;
        end
    end

    // Command decode; page count bits are never looked at
    always_comb begin
        next_cmd = '0;
        next_pkt = cmd_pkt;
        if (trail && pend_q) begin
            unique case (op_q)
                PBM_NOOP: begin
                end
                PBM_ALLOC: next_cmd.alloc = 1'b1;
                PBM_RESET: next_cmd.mmu_reset = 1'b1;
                PBM_RXPOP: next_cmd.rx_pop = 1'b1;
                PBM_RXREL: next_cmd.rx_release = 1'b1;
                PBM_PKTREL: next_cmd.pkt_release = 1'b1;
                PBM_ENQ: next_cmd.tx_enqueue = 1'b1;
                PBM_TXRST: next_cmd.tx_reset = 1'b1;
            endcase
            next_pkt = packet_select;
        end
    end

    // Busy tracking for release commands
    always_comb begin
        next_st = st;
        unique case (st)
            PBM_IDLE: begin
                if (next_cmd.rx_release || next_cmd.pkt_release) begin
                    next_st = PBM_BUSY;
                end
            end
            PBM_BUSY: begin
                if (release_done) begin
                    next_st = PBM_IDLE;
                end
            end
            default: next_st = PBM_IDLE;
        endcase
        if (next_cmd.mmu_reset) begin
            next_st = PBM_IDLE;
        end
    end

    // Allocation failed flag; a new request wins over a grant
    always_comb begin
        next_failed = alloc_failed;
        if (alloc_granted) begin
            next_failed = 1'b0;
        end
        if (next_cmd.alloc || next_cmd.mmu_reset) begin
            next_failed = 1'b1;
        end
    end

    // Read data; unmapped offsets return zero
    always_comb begin
        next_rdata = '0;
        if (!bus_rd_n && hit_cmd) begin
            next_rdata[PBM_BUSY_BIT] = st == PBM_BUSY;
        end else if (!bus_rd_n && hit_ctl) begin
            next_rdata = PBM_CTL_ONES;
            next_rdata[PBM_CTL_BAD] = ctl.bad_crc_accept;
            next_rdata[PBM_CTL_AUTO] = ctl.auto_release;
            next_rdata[PBM_CTL_LE] = ctl.link_change_irq_en;
            next_rdata[PBM_CTL_CR] = ctl.counter_wrap_irq_en;
            next_rdata[PBM_CTL_TE] = ctl.tx_error_irq_en;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wr_q <= 1'b0;
        end else begin
            wr_q <= wr_now;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctl <= '0;
        end else begin
            ctl <= next_ctl;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            op_q <= PBM_NOOP;
            pend_q <= 1'b0;
        end else begin
            op_q <= next_op;
            pend_q <= next_pend;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cmd <= '0;
            cmd_pkt <= '0;
        end else begin
            cmd <= next_cmd;
            cmd_pkt <= next_pkt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st <= PBM_IDLE;
            busy <= 1'b0;
        end else begin
            st <= next_st;
            busy <= next_st == PBM_BUSY;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            alloc_failed <= 1'b1;
        end else begin
            alloc_failed <= next_failed;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            bus_rdata <= '0;
        end else begin
            bus_rdata <= next_rdata;
        end
    end

    pbm_event_merge u_evt (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ctl(ctl),
        .link_ok(link_ok),
        .counter_wrap_flag(counter_wrap_flag),
        .counter_read(counter_read),
        .transmitter_on(transmitter_on),
        .tx_success(tx_success),
        .transmitter_on_write_one(transmitter_on_write_one),
        .rx_done(rx_done),
        .rx_crc_bad(rx_crc_bad),
        .txc(txc),
        .txa(txa),
        .rx_keep(rx_keep),
        .rx_discard(rx_discard),
        .phy_event_interrupt(phy_event_interrupt)
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_end(pbm_op_t o);
        trail && pend_q && op_q == o;
    endsequence

    sequence s_cmd_take;
        wr_now && hit_cmd && !bus_be_n[PBM_LANE_LO];
    endsequence

    noop_quiet_a: assert property (s_end(PBM_NOOP)
        |=> cmd == '0) else $error("noop issued a command");
    alloc_code_a: assert property (s_end(PBM_ALLOC)
        |=> cmd.alloc && alloc_failed) else $error("allocate not decoded");
    mmu_reset_a: assert property (s_end(PBM_RESET)
        |=> cmd.mmu_reset && !busy && alloc_failed) else $error("reset wrong");
    rx_pop_a: assert property (s_end(PBM_RXPOP)
        |=> cmd.rx_pop && !cmd.rx_release) else $error("pop wrong");
    rx_release_a: assert property ((st == PBM_IDLE) and s_end(PBM_RXREL)
        |=> cmd.rx_release && busy) else $error("release busy missing");
    busy_hold_a: assert property (busy && !release_done
        |=> busy || cmd.mmu_reset) else $error("busy dropped early");
    busy_clear_a: assert property (busy && release_done
        |=> !busy) else $error("busy not cleared");
    busy_read_a: assert property (!bus_rd_n && hit_cmd
        |=> bus_rdata[PBM_BUSY_BIT] == $past(busy)) else $error("busy read wrong");
    pkt_release_a: assert property (s_end(PBM_PKTREL)
        |=> cmd.pkt_release && cmd_pkt == $past(packet_select)) else $error("release wrong");
    pkt_hold_a: assert property (!(trail && pend_q)
        |=> $stable(cmd_pkt)) else $error("packet number moved");
    enqueue_a: assert property (s_end(PBM_ENQ)
        |=> cmd.tx_enqueue && cmd_pkt == $past(packet_select)) else $error("enqueue wrong");
    tx_reset_a: assert property (s_end(PBM_TXRST)
        |=> cmd.tx_reset && !cmd.mmu_reset) else $error("queue reset wrong");
    no_early_a: assert property (wr_now
        |=> cmd == '0) else $error("command before trailing edge");
    take_act_a: assert property (s_cmd_take ##1 !wr_now
        |=> cmd != '0 || op_q == PBM_NOOP) else $error("taken command not acted on");
    cmd_onehot_a: assert property ($onehot0(cmd))
        else $error("several commands at once");
    cmd_single_a: assert property (cmd != '0
        |=> cmd == '0) else $error("command longer than one cycle");
    ctl_lo_write_a: assert property (wr_now && hit_ctl && !bus_be_n[PBM_LANE_LO]
        |=> ctl.tx_error_irq_en == $past(bus_wdata[PBM_CTL_TE])) else $error("low lane lost");
    ctl_hi_write_a: assert property (wr_now && hit_ctl && !bus_be_n[PBM_LANE_HI]
        |=> ctl.bad_crc_accept == $past(bus_wdata[PBM_CTL_BAD])) else $error("high lane lost");
    ctl_hold_a: assert property (!(wr_now && hit_ctl)
        |=> $stable(ctl)) else $error("control changed without write");
    failed_clear_a: assert property (alloc_granted
        |=> !alloc_failed || cmd.alloc || cmd.mmu_reset) else $error("grant ignored");
endmodule : pbm_cmd_ctrl

//--- rtl/pbm_pkg.sv
package pbm_pkg;
    localparam int PBM_DW = 16;
    localparam logic [3:0] PBM_OFS_CMD = 4'h0;
    localparam logic [3:0] PBM_OFS_CTL = 4'hC;
    localparam logic [2:0] PBM_BANK_CMD = 3'h2;
    localparam logic [2:0] PBM_BANK_CTL = 3'h1;
    localparam int PBM_CTL_BAD = 14;
    localparam int PBM_CTL_AUTO = 11;
    localparam int PBM_CTL_LE = 7;
    localparam int PBM_CTL_CR = 6;
    localparam int PBM_CTL_TE = 5;
    localparam logic [15:0] PBM_CTL_ONES = 16'h1210;
    localparam int PBM_CMD_HI = 7;
    localparam int PBM_CMD_LO = 5;
    localparam int PBM_BUSY_BIT = 0;
    localparam int PBM_LANE_LO = 0;
    localparam int PBM_LANE_HI = 1;

    typedef enum logic [2:0] {
        PBM_NOOP = 3'h0,
        PBM_ALLOC = 3'h1,
        PBM_RESET = 3'h2,
        PBM_RXPOP = 3'h3,
        PBM_RXREL = 3'h4,
        PBM_PKTREL = 3'h5,
        PBM_ENQ = 3'h6,
        PBM_TXRST = 3'h7
    } pbm_op_t;

    typedef enum logic [1:0] {
        PBM_IDLE = 2'b00,
        PBM_BUSY = 2'b01
    } pbm_st_t;

    typedef struct packed {
        logic alloc;
        logic mmu_reset;
        logic rx_pop;
        logic rx_release;
        logic pkt_release;
        logic tx_enqueue;
        logic tx_reset;
    } pbm_cmd_t;

    typedef struct packed {
        logic bad_crc_accept;
        logic auto_release;
        logic link_change_irq_en;
        logic counter_wrap_irq_en;
        logic tx_error_irq_en;
    } pbm_ctl_t;

    typedef struct packed {
        logic done;
        logic success;
        logic queue_empty;
    } pbm_txc_t;

    typedef struct packed {
        logic free_pages;
        logic log_completion;
        logic tx_int;
        logic tx_empty_int;
        logic halt;
    } pbm_txa_t;
endpackage : pbm_pkg

//--- rtl/pbm_event_merge.sv
`timescale 1ns/1ps
module pbm_event_merge
    import pbm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire pbm_ctl_t ctl,
    input wire logic link_ok,
    input wire logic counter_wrap_flag,
    input wire logic counter_read,
    input wire logic transmitter_on,
    input wire logic tx_success,
    input wire logic transmitter_on_write_one,
    input wire logic rx_done,
    input wire logic rx_crc_bad,
    input wire pbm_txc_t txc,
    output pbm_txa_t txa,
    output logic rx_keep,
    output logic rx_discard,
    output logic phy_event_interrupt
);
    logic link_q, cw_q, ton_q, le_p, cr_p, te_p;
    logic next_le_p, next_cr_p, next_te_p, link_evt, cw_evt, tx_err;
    pbm_txa_t next_txa;

    always_comb begin
        link_evt = link_q != link_ok;
        cw_evt = counter_wrap_flag && !cw_q;
        tx_err = ton_q && !transmitter_on && !tx_success;
        next_le_p = ctl.link_change_irq_en && (le_p || link_evt);
        next_cr_p = ctl.counter_wrap_irq_en && (cw_evt || (cr_p && !counter_read));
        next_te_p = ctl.tx_error_irq_en && (tx_err || (te_p && !transmitter_on_write_one));
        next_txa = '0;
        if (txc.done) begin
            if (!ctl.auto_release) begin
                next_txa.log_completion = 1'b1;
                next_txa.tx_int = 1'b1;
            end else if (txc.success) begin
                next_txa.free_pages = 1'b1;
                next_txa.tx_empty_int = txc.queue_empty;
            end else begin
                next_txa.halt = 1'b1;
                next_txa.log_completion = 1'b1;
                next_txa.tx_int = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            {link_q, cw_q, ton_q, le_p, cr_p, te_p} <= '0;
            txa <= '0;
            rx_keep <= 1'b0;
            rx_discard <= 1'b0;
            phy_event_interrupt <= 1'b0;
        end else begin
            link_q <= link_ok;
            cw_q <= counter_wrap_flag;
            ton_q <= transmitter_on;
            le_p <= next_le_p;
            cr_p <= next_cr_p;
            te_p <= next_te_p;
            txa <= next_txa;
            rx_keep <= rx_done && (!rx_crc_bad || ctl.bad_crc_accept);
            rx_discard <= rx_done && rx_crc_bad && !ctl.bad_crc_accept;
            phy_event_interrupt <= next_le_p || next_cr_p || next_te_p;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    bad_crc_drop_a: assert property (rx_done && rx_crc_bad && !ctl.bad_crc_accept
        |=> rx_discard && !rx_keep)
        else $error("bad frame not dropped");
    auto_free_a: assert property (txc.done && txc.success && ctl.auto_release
        |=> txa.free_pages && !txa.log_completion && !txa.tx_int)
        else $error("auto release wrong");
    fatal_halt_a: assert property (txc.done && !txc.success && ctl.auto_release
        |=> txa.halt && txa.log_completion && !txa.free_pages)
        else $error("fatal error not halted");
    tx_err_irq_a: assert property (ctl.tx_error_irq_en && transmitter_on
        ##1 !transmitter_on && !tx_success && ctl.tx_error_irq_en
        |=> phy_event_interrupt) else $error("tx error not merged");
    link_ack_a: assert property (!ctl.link_change_irq_en && !ctl.counter_wrap_irq_en
        && !ctl.tx_error_irq_en |=> !phy_event_interrupt)
        else $error("disabled events raised");
endmodule : pbm_event_merge

//--- dv/pbm_host_model.sv
`timescale 1ns/1ps
module pbm_host_model
    import pbm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [PBM_DW-1:0] bus_rdata,
    output logic [2:0] bus_bank,
    output logic [3:0] bus_addr,
    output logic [1:0] bus_be_n,
    output logic bus_wr_n,
    output logic bus_rd_n,
    output logic [PBM_DW-1:0] bus_wdata
);
    initial begin
        bus_bank = 3'h0;
        bus_addr = 4'h0;
        bus_be_n = 2'h3;
        bus_wr_n = 1'b1;
        bus_rd_n = 1'b1;
        bus_wdata = 16'h0000;
    end
    // Strobe held over one edge; data goes stale once the strobe is gone
    task automatic wr(input logic [2:0] bk, input logic [3:0] ad, input logic [1:0] be,
                      input logic [15:0] d);
        @(posedge sys_clk) #1;
        bus_bank = bk;
        bus_addr = ad;
        bus_be_n = be;
        bus_wdata = d;
        bus_wr_n = 1'b0;
        @(posedge sys_clk) #1;
        bus_wr_n = 1'b1;
        bus_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [2:0] bk, input logic [3:0] ad, output logic [15:0] d);
        @(posedge sys_clk) #1;
        bus_bank = bk;
        bus_addr = ad;
        bus_rd_n = 1'b0;
        @(posedge sys_clk) #1;
        d = bus_rdata;
        bus_rd_n = 1'b1;
    endtask : rd
    task automatic ctl_wr(input logic [1:0] be, input logic [15:0] d);
        wr(PBM_BANK_CTL, PBM_OFS_CTL, be, d & 16'hFFF8);
    endtask : ctl_wr
    task automatic cmd_wr(input logic [2:0] op, input logic [1:0] be, input logic [2:0] pc);
        wr(PBM_BANK_CMD, PBM_OFS_CMD, be, {8'h00, op, 2'b00, (op == PBM_ALLOC) ? pc : 3'h0});
    endtask : cmd_wr
endmodule : pbm_host_model

//--- dv/packet_buffer_mmu_command_control_tb.sv
`timescale 1ns/1ps
module packet_buffer_mmu_command_control_tb
    import pbm_pkg::*;
;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] bus_bank;
    logic [3:0] bus_addr;
    logic [1:0] bus_be_n, be;
    logic bus_wr_n, bus_rd_n, release_done, alloc_granted, busy, alloc_failed, ok;
    logic [15:0] bus_wdata, bus_rdata, ctl_reg, rv;
    logic [5:0] packet_select, cmd_pkt;
    logic link_ok, counter_wrap_flag, counter_read, transmitter_on, tx_success;
    logic transmitter_on_write_one, rx_done, rx_crc_bad, rx_keep, rx_discard, phy_event_interrupt;
    pbm_cmd_t cmd;
    pbm_ctl_t ctl;
    pbm_txc_t txc;
    pbm_txa_t txa;
    int fail_count = 0;
    int n_checks = 0;
    int seed = 32'h41dd;
    int cnt[7] = '{default: 0};
    int exp_cnt[7] = '{default: 0};

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    pbm_cmd_ctrl dut_u (
        .sys_clk, .nrst, .bus_bank, .bus_addr, .bus_be_n, .bus_wr_n, .bus_rd_n,
        .bus_wdata, .bus_rdata, .packet_select, .release_done, .alloc_granted, .cmd,
        .cmd_pkt, .busy, .alloc_failed, .ctl, .link_ok, .counter_wrap_flag, .counter_read,
        .transmitter_on, .tx_success, .transmitter_on_write_one, .rx_done, .rx_crc_bad, .txc, .txa,
        .rx_keep, .rx_discard, .phy_event_interrupt
    );
    pbm_host_model host_u (
        .sys_clk, .bus_rdata, .bus_bank, .bus_addr, .bus_be_n, .bus_wr_n, .bus_rd_n,
        .bus_wdata
    );

    always @(posedge sys_clk) begin
        for (int i = 0; i < 7; i++) if (cmd[i] === 1'b1) cnt[i]++;
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_reg(input logic [2:0] bk, input logic [3:0] ad, input logic [15:0] e);
        logic [15:0] d;
        host_u.rd(bk, ad, d);
        chk("register read", e, d);
    endtask : chk_reg
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task automatic set_ctl(input logic [15:0] v);
        host_u.ctl_wr(2'b00, v);
        ctl_reg = v;
    endtask : set_ctl
    task automatic pchk(input logic e);
        step(3);
        chk("phy_event_interrupt", 16'(e), 16'(phy_event_interrupt));
    endtask : pchk
    task automatic issue(input logic [2:0] op, input logic [1:0] lanes);
        host_u.cmd_wr(op, lanes, 3'($random(seed)));
        if (!lanes[0] && op != 3'h0) exp_cnt[7 - op]++;
        step(4);
        for (int i = 0; i < 7; i++) chk("cmd pulses", 16'(exp_cnt[i]), 16'(cnt[i]));
    endtask : issue
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    initial begin
        #(50 * 20000);
        fail_count++;
        $display("FAIL watchdog expected finish seen hang");
        finish_test();
    end

    initial begin
        {release_done, alloc_granted, link_ok, counter_wrap_flag, counter_read} = '0;
        {transmitter_on, tx_success, transmitter_on_write_one, rx_done, rx_crc_bad} = '0;
        packet_select = 6'h00;
        txc = '0;
        ctl_reg = 16'h0000;
        repeat (20) @(posedge sys_clk);
        #1 nrst = 1'b1;
        chk("alloc_failed", 16'h0001, 16'(alloc_failed));
        chk("ctl", 16'h0000, 16'(ctl));
        chk_reg(PBM_BANK_CTL, PBM_OFS_CTL, PBM_CTL_ONES);
        $display("TEST reset done");
        for (int k = 0; k < 8; k++) begin
            rv = 16'($random(seed));
            be = 2'($random(seed));
            host_u.ctl_wr(be, rv);
            if (!be[0]) ctl_reg[7:0] = rv[7:0];
            if (!be[1]) ctl_reg[15:8] = rv[15:8];
            chk_reg(PBM_BANK_CTL, PBM_OFS_CTL, (ctl_reg & 16'h48E0) | PBM_CTL_ONES);
            chk("ctl", {11'h0, ctl_reg[14], ctl_reg[11], ctl_reg[7:5]}, 16'(ctl));
        end
        chk_reg(PBM_BANK_CTL, 4'hA, 16'h0000);
        chk_reg(PBM_BANK_CMD, PBM_OFS_CMD, 16'h0000);
        $display("TEST control done");
        for (int op = 0; op < 8; op++) begin
            packet_select = 6'($random(seed));
            alloc_granted = 1'b1;
            step(1);
            alloc_granted = 1'b0;
            issue(3'(op), 2'b10);
            chk("alloc_failed", 16'(op == 1 || op == 2), 16'(alloc_failed));
            if (op == 5 || op == 6) chk("cmd_pkt", 16'(packet_select), 16'(cmd_pkt));
            if (op == 4 || op == 5) begin
                chk("busy", 16'h0001, 16'(busy));
                chk_reg(PBM_BANK_CMD, PBM_OFS_CMD, 16'h0001);
                release_done = 1'b1;
                step(1);
                release_done = 1'b0;
                step(2);
            end
            chk("busy", 16'h0000, 16'(busy));
        end
        issue(3'h6, 2'b01);
        issue(3'h4, 2'b10);
        issue(3'h2, 2'b10);
        chk("busy", 16'h0000, 16'(busy));
        issue(3'h5, 2'b10);
        nrst = 1'b0;
        step(2);
        nrst = 1'b1;
        chk("busy after reset", 16'h0000, 16'(busy));
        chk("alloc_failed after reset", 16'h0001, 16'(alloc_failed));
        chk("ctl after reset", 16'h0000, 16'(ctl));
        chk("cmd_pkt after reset", 16'h0000, 16'(cmd_pkt));
        $display("TEST commands done");
        for (int k = 0; k < 4; k++) begin
            set_ctl({1'b0, k[1], 14'h0000});
            rx_done = 1'b1;
            rx_crc_bad = k[0];
            step(1);
            rx_done = 1'b0;
            chk("rx keep discard", {14'h0, ~k[0] | k[1], k[0] & ~k[1]},
                {14'h0, rx_keep, rx_discard});
        end
        for (int k = 0; k < 8; k++) begin
            set_ctl({4'h0, k[2], 11'h000});
            txc = {1'b1, k[1], k[0]};
            step(1);
            txc = '0;
            ok = k[2] & k[1];
            chk("tx action", {12'h0, ok, ~ok, ~ok, k[2] & ~k[1]},
                {12'h0, txa.free_pages, txa.log_completion, txa.tx_int, txa.halt});
            chk("tx empty int", 16'(ok & k[0]), 16'(txa.tx_empty_int));
        end
        $display("TEST completion done");
        set_ctl(16'h0000);
        transmitter_on = 1'b1;
        link_ok = 1'b1;
        pchk(1'b0);
        set_ctl(16'h0080);
        link_ok = 1'b0;
        pchk(1'b1);
        set_ctl(16'h0000);
        pchk(1'b0);
        set_ctl(16'h0040);
        counter_wrap_flag = 1'b1;
        pchk(1'b1);
        counter_read = 1'b1;
        step(1);
        counter_read = 1'b0;
        pchk(1'b0);
        set_ctl(16'h0020);
        tx_success = 1'b1;
        transmitter_on = 1'b0;
        pchk(1'b0);
        tx_success = 1'b0;
        transmitter_on = 1'b1;
        step(1);
        transmitter_on = 1'b0;
        pchk(1'b1);
        transmitter_on_write_one = 1'b1;
        step(1);
        transmitter_on_write_one = 1'b0;
        pchk(1'b0);
        $display("TEST events done");
        finish_test();
    end
endmodule : packet_buffer_mmu_command_control_tb
